// [hw/servo_stop_sequencer.sv]
// Summary of operation
// - torque limit flag, never in torque mode
// - torque limit flag off while servo off
// - warning output on while any warning
// - warning output released about 3 s after power-up
// - battery output on for either battery warning
// - battery output released about 3 s after power-up
// - variable gain output follows variable gain
// - absolute unknown flag, position mode only
// - ride-through flag when tough drive enabled
// - forced stop decelerates, brakes, shows warning
// - decel by time constant, then zero-speed shutoff
// - communication loss starts same stop sequence
// - no forced stop decel in torque mode
// - brake interlock off first, delay, then shutoff
// - freefall compensation only under three conditions
// - dynamic-brake alarms skip deceleration
// - dynamic-brake alarm aborts running deceleration
// - alarm clears by reset command, cause removed
// - zero speed default 50 r/min, adjustable
// - zero speed releases 20 r/min above threshold
`timescale 1ns/1ns
module servo_stop_sequencer #(
  parameter int MS_CYCLES      = servo_stop_pkg::MS_CYCLES,
  parameter int POWERUP_CYCLES = servo_stop_pkg::POWERUP_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [5:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  input  wire logic               forced_stop_input,
  input  wire logic               comm_lost,
  input  wire logic               alarm_active,
  input  wire logic               alarm_dyn_brake,
  input  wire logic               servo_on,
  input  wire logic signed [15:0] motor_speed,
  input  wire logic [15:0]        torque_magnitude,
  input  wire logic               other_warning,
  input  wire logic               battery_cable_open_warning,
  input  wire logic               battery_low_warning,
  input  wire logic               variable_gain_in,
  input  wire logic               abs_position_known,
  input  wire logic               power_fail_ride_through,
  output logic                    torque_limit_reached,
  output logic                    general_warning_out,
  output logic                    battery_warning_out,
  output logic                    variable_gain_active,
  output logic                    abs_position_unknown,
  output logic                    ride_through_active,
  output logic                    brake_interlock_out,
  output logic                    decel_active,
  output logic                    base_shutoff,
  output logic                    dynamic_brake_on,
  output logic                    freefall_comp_active,
  output logic                    servo_forced_stop_warning,
  output logic                    zero_speed_detected
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                 wait_n;
    logic [31:0]          rdata;
    logic [2:0]           control;
    logic [15:0]          torque_limit;
    logic [15:0]          decel_time;
    logic [15:0]          zero_speed_threshold;
    logic [15:0]          base_shutoff_delay;
    logic [15:0]          freefall_comp_amount;
    servo_stop_pkg::seq_t seq;
    logic [15:0]          timer;
    logic [31:0]          ms_cnt;
    logic [31:0]          pwr_cnt;
    logic                 pwr_done;
    logic                 alarm_latched;
    logic                 cause_fs;
    logic                 zero;
    logic                 tlr;
    logic                 gwarn;
    logic                 bwarn;
    logic                 vgain;
    logic                 absu;
    logic                 ride;
    logic                 brake;
    logic                 decel;
    logic                 bso;
    logic                 dbrake;
    logic                 ffc;
    logic                 fswarn;
  } state_t;

  state_t s;
  state_t next_s;

  logic [15:0] speed_mag;
  logic        torque_mode;
  logic        trigger;
  logic        tick;
  logic        clear_cmd;
  logic        acc;
  logic [16:0] release_level;

  assign speed_mag     = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
  assign torque_mode   = s.control[1:0] == servo_stop_pkg::MODE_TORQUE;
  assign tick          = s.ms_cnt == 32'(MS_CYCLES - 1);
  assign acc           = (read || write) && !s.wait_n;
  assign release_level = {1'b0, s.zero_speed_threshold} + {1'b0, servo_stop_pkg::ZERO_SPEED_HYST};
  assign clear_cmd     = write && s.wait_n && address == servo_stop_pkg::OFS_COMMAND
                         && (writedata[servo_stop_pkg::CMD_ERR_RST_BIT]
                             || writedata[servo_stop_pkg::CMD_CPU_RST_BIT]);
  assign trigger       = !forced_stop_input || comm_lost || alarm_active || s.alarm_latched;

  always_comb begin
    next_s = s;
    // ----------------------------------------
    // bus slave: one wait cycle, then answer
    // ----------------------------------------
    next_s.wait_n = acc;
    if (read && !s.wait_n) begin
      unique case (address)
        servo_stop_pkg::OFS_CONTROL:      next_s.rdata = {29'h0, s.control};
        servo_stop_pkg::OFS_TORQUE_LIMIT: next_s.rdata = {16'h0, s.torque_limit};
        servo_stop_pkg::OFS_DECEL_TIME:   next_s.rdata = {16'h0, s.decel_time};
        servo_stop_pkg::OFS_ZERO_SPEED:   next_s.rdata = {16'h0, s.zero_speed_threshold};
        servo_stop_pkg::OFS_SHUTOFF_DLY:  next_s.rdata = {16'h0, s.base_shutoff_delay};
        servo_stop_pkg::OFS_FREEFALL:     next_s.rdata = {16'h0, s.freefall_comp_amount};
        servo_stop_pkg::OFS_STATUS:       next_s.rdata = {22'h0, s.alarm_latched, s.zero,
                                                          s.fswarn, s.ffc, s.dbrake, s.bso,
                                                          s.decel, s.brake, s.seq};
        default:                          next_s.rdata = 32'h0;
      endcase
    end
    if (write && s.wait_n) begin
      unique case (address)
        servo_stop_pkg::OFS_CONTROL:      next_s.control = writedata[2:0];
        servo_stop_pkg::OFS_TORQUE_LIMIT: next_s.torque_limit = writedata[15:0];
        servo_stop_pkg::OFS_DECEL_TIME:   next_s.decel_time = writedata[15:0];
        servo_stop_pkg::OFS_ZERO_SPEED:   next_s.zero_speed_threshold = writedata[15:0];
        servo_stop_pkg::OFS_SHUTOFF_DLY:  next_s.base_shutoff_delay = writedata[15:0];
        servo_stop_pkg::OFS_FREEFALL:     next_s.freefall_comp_amount = writedata[15:0];
        default:                          next_s.control = s.control;
      endcase
    end
    // ----------------------------------------
    // timebase and power-up hold
    // ----------------------------------------
    next_s.ms_cnt = tick ? 32'h0 : s.ms_cnt + 32'h1;
    if (!s.pwr_done) begin
      next_s.pwr_cnt  = s.pwr_cnt + 32'h1;
      next_s.pwr_done = s.pwr_cnt >= 32'(POWERUP_CYCLES - 1);
    end
    // ----------------------------------------
    // alarm latch, set wins over clear
    // ----------------------------------------
    next_s.alarm_latched = alarm_active || (s.alarm_latched && !clear_cmd);
    // ----------------------------------------
    // zero speed with hysteresis
    // ----------------------------------------
    if ({1'b0, speed_mag} > release_level) begin
      next_s.zero = 1'b0;
    end else if (speed_mag <= s.zero_speed_threshold) begin
      next_s.zero = 1'b1;
    end
    // ----------------------------------------
    // stop sequencer
    // ----------------------------------------
    if (tick && s.timer != 16'h0) begin
      next_s.timer = s.timer - 16'h1;
    end
    unique case (s.seq)
      servo_stop_pkg::SEQ_RUN: begin
        if (trigger) begin
          next_s.cause_fs = !forced_stop_input;
          next_s.ffc = s.zero && s.freefall_comp_amount != 16'h0
                       && s.base_shutoff_delay != 16'h0;
          if (alarm_dyn_brake) begin
            next_s.seq   = servo_stop_pkg::SEQ_DELAY;
            next_s.timer = s.base_shutoff_delay;
            next_s.ffc   = 1'b0;
          end else if (torque_mode) begin
            next_s.seq   = servo_stop_pkg::SEQ_DELAY;
            next_s.timer = s.base_shutoff_delay;
          end else begin
            next_s.seq   = servo_stop_pkg::SEQ_DECEL;
            next_s.timer = s.decel_time;
          end
        end
      end
      servo_stop_pkg::SEQ_DECEL: begin
        if (alarm_dyn_brake) begin
          next_s.seq = servo_stop_pkg::SEQ_SHUTOFF;
          next_s.ffc = 1'b0;
        end else if (s.timer == 16'h0 && s.zero) begin
          next_s.seq   = servo_stop_pkg::SEQ_DELAY;
          next_s.timer = s.base_shutoff_delay;
        end
      end
      servo_stop_pkg::SEQ_DELAY: begin
        if (alarm_dyn_brake || s.timer == 16'h0) begin
          next_s.seq = servo_stop_pkg::SEQ_SHUTOFF;
          next_s.ffc = 1'b0;
        end
      end
      servo_stop_pkg::SEQ_SHUTOFF: begin
        if (!trigger) begin
          next_s.seq      = servo_stop_pkg::SEQ_RUN;
          next_s.cause_fs = 1'b0;
        end
      end
    endcase
    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    next_s.decel  = next_s.seq == servo_stop_pkg::SEQ_DECEL;
    next_s.brake  = next_s.seq == servo_stop_pkg::SEQ_RUN && servo_on;
    next_s.bso    = next_s.seq == servo_stop_pkg::SEQ_SHUTOFF;
    next_s.dbrake = next_s.seq == servo_stop_pkg::SEQ_SHUTOFF;
    next_s.fswarn = next_s.seq != servo_stop_pkg::SEQ_RUN && next_s.cause_fs;
    next_s.tlr    = servo_on && !torque_mode
                    && torque_magnitude >= s.torque_limit;
    next_s.gwarn  = other_warning || battery_cable_open_warning || battery_low_warning
                    || next_s.fswarn || !s.pwr_done;
    next_s.bwarn  = battery_cable_open_warning || battery_low_warning || !s.pwr_done;
    next_s.vgain  = variable_gain_in;
    next_s.absu   = !abs_position_known
                    && s.control[1:0] == servo_stop_pkg::MODE_POSITION;
    next_s.ride   = s.control[servo_stop_pkg::CTRL_TOUGH_BIT] && power_fail_ride_through;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s                      <= '0;
      s.control              <= servo_stop_pkg::CONTROL_RST;
      s.torque_limit         <= servo_stop_pkg::TORQUE_LIMIT_RST;
      s.decel_time           <= servo_stop_pkg::DECEL_TIME_RST;
      s.zero_speed_threshold <= servo_stop_pkg::ZERO_SPEED_RST;
      s.base_shutoff_delay   <= servo_stop_pkg::SHUTOFF_DLY_RST;
      s.freefall_comp_amount <= servo_stop_pkg::FREEFALL_RST;
      s.seq                  <= servo_stop_pkg::SEQ_RUN;
      s.gwarn                <= 1'b1;
      s.bwarn                <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign readdata                  = s.rdata;
  assign waitrequest               = !s.wait_n;
  assign torque_limit_reached      = s.tlr;
  assign general_warning_out       = s.gwarn;
  assign battery_warning_out       = s.bwarn;
  assign variable_gain_active      = s.vgain;
  assign abs_position_unknown      = s.absu;
  assign ride_through_active       = s.ride;
  assign brake_interlock_out       = s.brake;
  assign decel_active              = s.decel;
  assign base_shutoff              = s.bso;
  assign dynamic_brake_on          = s.dbrake;
  assign freefall_comp_active      = s.ffc;
  assign servo_forced_stop_warning = s.fswarn;
  assign zero_speed_detected       = s.zero;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_tlc_servo_off: assert property (!servo_on |=> !torque_limit_reached)
    else $error("torque limit flag set while servo off");
  a_tlc_torque_mode: assert property (torque_mode |=> !torque_limit_reached)
    else $error("torque limit flag set in torque mode");
  a_warn_follow: assert property (other_warning |=> general_warning_out)
    else $error("warning output missing");
  a_powerup_hold: assert property (!s.pwr_done |=> general_warning_out && battery_warning_out)
    else $error("warning outputs released before power-up time");
  a_battery_warn: assert property (
    battery_low_warning || battery_cable_open_warning |=> battery_warning_out)
    else $error("battery warning output missing");
  a_db_bypass: assert property (
    s.seq == servo_stop_pkg::SEQ_RUN && trigger && alarm_dyn_brake
    |=> ##1 dynamic_brake_on && !decel_active)
    else $error("dynamic brake alarm did not bypass deceleration");
  a_db_abort: assert property (
    s.seq == servo_stop_pkg::SEQ_DECEL && alarm_dyn_brake |=> dynamic_brake_on)
    else $error("deceleration not abandoned on dynamic brake alarm");
  a_brake_first: assert property (
    $rose(base_shutoff) |-> !brake_interlock_out && !$past(brake_interlock_out))
    else $error("base shutoff before brake interlock release");
  a_torque_nodecel: assert property (
    torque_mode && s.seq == servo_stop_pkg::SEQ_RUN && trigger && !alarm_dyn_brake
    |=> s.seq == servo_stop_pkg::SEQ_DELAY)
    else $error("deceleration entered in torque mode");
  a_vgain_follow: assert property (variable_gain_in |=> variable_gain_active)
    else $error("variable gain output missing");
  a_abs_unknown: assert property (
    !abs_position_known && s.control[1:0] == servo_stop_pkg::MODE_POSITION
    |=> abs_position_unknown)
    else $error("absolute position unknown flag missing");
  a_abs_mode: assert property (
    s.control[1:0] != servo_stop_pkg::MODE_POSITION |=> !abs_position_unknown)
    else $error("absolute position flag outside position mode");
  a_ride_flag: assert property (
    s.control[servo_stop_pkg::CTRL_TOUGH_BIT] && power_fail_ride_through
    |=> ride_through_active)
    else $error("ride-through flag missing");
  a_fs_warn: assert property (
    s.seq == servo_stop_pkg::SEQ_RUN && !forced_stop_input |=> servo_forced_stop_warning)
    else $error("forced stop warning missing");
  a_comm_stop: assert property (
    s.seq == servo_stop_pkg::SEQ_RUN && comm_lost |=> !brake_interlock_out)
    else $error("communication loss did not start stop");
  a_decel_hold: assert property (
    s.seq == servo_stop_pkg::SEQ_DECEL && !s.zero && !alarm_dyn_brake |=> decel_active)
    else $error("deceleration left before zero speed");
  a_ffc_zero: assert property (
    $rose(freefall_comp_active) |-> $past(zero_speed_detected))
    else $error("freefall compensation armed above zero speed");
  a_zero_release: assert property (
    {1'b0, speed_mag} > release_level |=> !zero_speed_detected)
    else $error("zero speed held above release level");
  a_shutoff_hold: assert property (
    s.seq == servo_stop_pkg::SEQ_SHUTOFF && trigger |=> base_shutoff)
    else $error("shutoff left while stop cause present");
  a_alarm_hold: assert property (s.alarm_latched && !clear_cmd |=> s.alarm_latched)
    else $error("alarm cleared without reset command");

endmodule

// [hw/servo_stop_pkg.sv]
package servo_stop_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] OFS_CONTROL      = 6'h00;
  localparam logic [5:0] OFS_TORQUE_LIMIT = 6'h04;
  localparam logic [5:0] OFS_DECEL_TIME   = 6'h08;
  localparam logic [5:0] OFS_ZERO_SPEED   = 6'h0c;
  localparam logic [5:0] OFS_SHUTOFF_DLY  = 6'h10;
  localparam logic [5:0] OFS_FREEFALL     = 6'h14;
  localparam logic [5:0] OFS_COMMAND      = 6'h18;
  localparam logic [5:0] OFS_STATUS       = 6'h1c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_TOUGH_BIT  = 2;
  localparam int CMD_ERR_RST_BIT = 0;
  localparam int CMD_CPU_RST_BIT = 1;

  // ----------------------------------------
  // control modes
  // ----------------------------------------
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED    = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;

  // ----------------------------------------
  // values after reset, and zero speed hysteresis
  // ----------------------------------------
  localparam logic [2:0]  CONTROL_RST      = 3'h0;
  localparam logic [15:0] TORQUE_LIMIT_RST = 16'h03e8;
  localparam logic [15:0] DECEL_TIME_RST   = 16'h0064;
  localparam logic [15:0] ZERO_SPEED_RST   = 16'h0032;
  localparam logic [15:0] SHUTOFF_DLY_RST  = 16'h0000;
  localparam logic [15:0] FREEFALL_RST     = 16'h0000;
  localparam logic [15:0] ZERO_SPEED_HYST  = 16'h0014;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ           = 100_000_000;
  localparam int MS_TIME_MS       = 1;
  localparam int MS_CYCLES        = MS_TIME_MS * (CLK_HZ / 1000);
  localparam int POWERUP_TIME_MS  = 3000;
  localparam int POWERUP_CYCLES   = POWERUP_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // stop sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEQ_RUN     = 2'b00,
    SEQ_DECEL   = 2'b01,
    SEQ_DELAY   = 2'b10,
    SEQ_SHUTOFF = 2'b11
  } seq_t;

endpackage

// [tb/servo_ctrl_model.sv]
`timescale 1ns/1ns
module servo_ctrl_model (
  input  wire logic        clk,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic             comm_lost
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    comm_lost = 1'b0;
  end
  // ----------------------------------------
  // bus master and network link
  // ----------------------------------------
  task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    read      <= ~w;
    write     <= w;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic cfg(input int dec, input int dly, input int ff);
    logic [31:0] q;
    xfer(servo_stop_pkg::OFS_DECEL_TIME, 1'b1, 32'(dec), q);
    xfer(servo_stop_pkg::OFS_SHUTOFF_DLY, 1'b1, 32'(dly), q);
    xfer(servo_stop_pkg::OFS_FREEFALL, 1'b1, 32'(ff), q);
  endtask
  task automatic clear_alarm(input int b);
    logic [31:0] q;
    xfer(servo_stop_pkg::OFS_COMMAND, 1'b1, 32'h1 << b, q);
  endtask
  task automatic set_comm(input logic v);
    comm_lost <= v;
  endtask
endmodule

// [tb/test_servo_stop_sequencer.sv]
`timescale 1ns/1ns
module test_servo_stop_sequencer;
  logic clk, reset, read, write, waitrequest, comm_lost, forced_stop_input;
  logic alarm_active, alarm_dyn_brake, servo_on, other_warning, variable_gain_in;
  logic battery_cable_open_warning, battery_low_warning, abs_position_known;
  logic power_fail_ride_through, torque_limit_reached, general_warning_out;
  logic battery_warning_out, variable_gain_active, abs_position_unknown;
  logic ride_through_active, brake_interlock_out, decel_active, base_shutoff;
  logic dynamic_brake_on, freefall_comp_active, servo_forced_stop_warning;
  logic zero_speed_detected, zs;
  logic        [5:0]  address;
  logic        [31:0] writedata, readdata, v;
  logic signed [15:0] motor_speed;
  logic        [15:0] torque_magnitude;
  logic        [1:0]  md;
  int err_count, checked, seed, spd, thr, tq;
  int cs [5][5] = '{'{5,3,0,0,0}, '{0,3,0,1,0}, '{5,0,0,1,1}, '{5,3,200,1,0}, '{0,2,0,0,2}};

  servo_stop_sequencer #(.MS_CYCLES(4), .POWERUP_CYCLES(50)) i_servo_stop_sequencer (
    .clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .forced_stop_input, .comm_lost, .alarm_active, .alarm_dyn_brake, .servo_on,
    .motor_speed, .torque_magnitude, .other_warning, .battery_cable_open_warning,
    .battery_low_warning, .variable_gain_in, .abs_position_known,
    .power_fail_ride_through, .torque_limit_reached, .general_warning_out,
    .battery_warning_out, .variable_gain_active, .abs_position_unknown,
    .ride_through_active, .brake_interlock_out, .decel_active, .base_shutoff,
    .dynamic_brake_on, .freefall_comp_active, .servo_forced_stop_warning,
    .zero_speed_detected);
  servo_ctrl_model i_servo_ctrl_model (.clk, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .comm_lost);

  always #5 clk = ~clk;
  // ----------------------------------------
  // helpers and reference model
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input int d);
    logic [31:0] q;
    i_servo_ctrl_model.xfer(a, 1'b1, 32'(d), q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_servo_ctrl_model.xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic zupd(logic z, int s, int t);
    int a;
    a = s < 0 ? -s : s;
    if (a <= t) return 1'b1;
    if (a > t + 20) return 1'b0;
    return z;
  endfunction
  task automatic summarize;
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic stop_case(input int ff, input int dly, input int sp, input int fs,
                           input int mode);
    int n;
    wr(servo_stop_pkg::OFS_CONTROL, mode);
    i_servo_ctrl_model.cfg(2, dly, ff);
    servo_on <= 1'b1;
    motor_speed <= 16'(sp);
    cyc(3);
    if (fs != 0) forced_stop_input <= 1'b0;
    else i_servo_ctrl_model.set_comm(1'b1);
    cyc(3);
    chk(freefall_comp_active, ff != 0 && dly != 0 && sp <= 50);
    chk(decel_active, mode != 2);
    chk(brake_interlock_out, 0);
    chk(base_shutoff, 0);
    chk(servo_forced_stop_warning, fs != 0);
    chk(general_warning_out, fs != 0);
    if (sp > 50) begin
      cyc(16);
      chk(decel_active, 1);
      motor_speed <= 16'h0000;
    end
    n = 0;
    while (base_shutoff !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(n >= (dly - 1) * 4 && n <= (dly + 4) * 4 + 8, 1);
    chk(dynamic_brake_on, 1);
    chk(decel_active, 0);
    cyc(8);
    chk(base_shutoff, 1);
    rdchk(servo_stop_pkg::OFS_STATUS, 32'h133 | (32'(fs != 0) << 7));
    forced_stop_input <= 1'b1;
    i_servo_ctrl_model.set_comm(1'b0);
    cyc(3);
    chk(base_shutoff, 0);
    chk(brake_interlock_out, 1);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, alarm_active, alarm_dyn_brake, servo_on} = '0;
    {other_warning, battery_cable_open_warning, battery_low_warning} = '0;
    {variable_gain_in, abs_position_known, power_fail_ride_through} = '0;
    reset = 1'b1;
    forced_stop_input = 1'b1;
    motor_speed = 16'h0000;
    torque_magnitude = 16'h0000;
    err_count = 0;
    checked = 0;
    seed = 11528;
    spd = 0;
    zs = 1'b1;
    cyc(4);
    reset <= 1'b0;
    cyc(38);
    chk(general_warning_out, 1);
    chk(battery_warning_out, 1);
    cyc(24);
    chk(general_warning_out, 0);
    chk(battery_warning_out, 0);
    rdchk(servo_stop_pkg::OFS_CONTROL, servo_stop_pkg::CONTROL_RST);
    rdchk(servo_stop_pkg::OFS_TORQUE_LIMIT, servo_stop_pkg::TORQUE_LIMIT_RST);
    rdchk(servo_stop_pkg::OFS_DECEL_TIME, servo_stop_pkg::DECEL_TIME_RST);
    rdchk(servo_stop_pkg::OFS_ZERO_SPEED, servo_stop_pkg::ZERO_SPEED_RST);
    rdchk(servo_stop_pkg::OFS_SHUTOFF_DLY, servo_stop_pkg::SHUTOFF_DLY_RST);
    rdchk(6'h20, 32'h0);
    wr(servo_stop_pkg::OFS_TORQUE_LIMIT, 500);
    rdchk(servo_stop_pkg::OFS_TORQUE_LIMIT, 32'h1f4);
    for (int k = 0; k < 2; k++) begin
      thr = 30 + 20 * k;
      wr(servo_stop_pkg::OFS_ZERO_SPEED, thr);
      zs = zupd(zs, spd, thr);
      repeat (40) begin
        v = $random(seed);
        md = 2'(v[1:0] % 3);
        wr(servo_stop_pkg::OFS_CONTROL, {v[2], md});
        {power_fail_ride_through, abs_position_known, variable_gain_in} <= v[9:7];
        {battery_low_warning, battery_cable_open_warning} <= v[6:5];
        {other_warning, servo_on} <= v[4:3];
        tq = 470 + v[15:10];
        torque_magnitude <= 16'(tq);
        spd = $random(seed) % 121;
        motor_speed <= 16'(spd);
        cyc(3);
        zs = zupd(zs, spd, thr);
        chk(zero_speed_detected, zs);
        chk(torque_limit_reached, v[3] && md != 2 && tq >= 500);
        chk(general_warning_out, |v[6:4]);
        chk(battery_warning_out, |v[6:5]);
        chk(variable_gain_active, v[7]);
        chk(abs_position_unknown, !v[8] && md == 0);
        chk(ride_through_active, v[2] && v[9]);
        chk(brake_interlock_out, v[3]);
      end
    end
    {other_warning, battery_cable_open_warning, battery_low_warning} <= '0;
    for (int k = 0; k < 5; k++) stop_case(cs[k][0], cs[k][1], cs[k][2], cs[k][3], cs[k][4]);
    wr(servo_stop_pkg::OFS_CONTROL, 0);
    motor_speed <= 16'd200;
    forced_stop_input <= 1'b0;
    cyc(3);
    chk(decel_active, 1);
    {alarm_active, alarm_dyn_brake} <= 2'b11;
    cyc(3);
    chk(base_shutoff, 1);
    chk(decel_active, 0);
    forced_stop_input <= 1'b1;
    alarm_dyn_brake <= 1'b0;
    i_servo_ctrl_model.clear_alarm(servo_stop_pkg::CMD_ERR_RST_BIT);
    cyc(3);
    chk(base_shutoff, 1);
    alarm_active <= 1'b0;
    cyc(6);
    chk(base_shutoff, 1);
    i_servo_ctrl_model.clear_alarm(servo_stop_pkg::CMD_CPU_RST_BIT);
    cyc(3);
    chk(base_shutoff, 0);
    {alarm_active, alarm_dyn_brake} <= 2'b11;
    cyc(3);
    chk(base_shutoff, 1);
    chk(decel_active, 0);
    {alarm_active, alarm_dyn_brake} <= 2'b00;
    i_servo_ctrl_model.clear_alarm(servo_stop_pkg::CMD_ERR_RST_BIT);
    cyc(3);
    chk(base_shutoff, 0);
    summarize();
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
